// >>> core/dual_port_internal_sram.sv
// Two-block dual-ported internal memory with address decode and aliasing
`timescale 1ns/1ps
module dual_port_internal_sram import sram_pkg::*; #(
  parameter int BLOCK_COUNT = BLOCKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic dm_req,
  input wire logic dm_we,
  input wire acc_width_type dm_width,
  input wire logic [ADDR_W-1:0] dm_addr,
  input wire logic [DATA_W-1:0] dm_wdata,
  output logic [DATA_W-1:0] dm_rdata,
  output logic dm_done,
  output logic dm_err,
  input wire logic pm_req,
  input wire logic pm_we,
  input wire acc_width_type pm_width,
  input wire logic [ADDR_W-1:0] pm_addr,
  input wire logic [DATA_W-1:0] pm_wdata,
  output logic [DATA_W-1:0] pm_rdata,
  output logic pm_done,
  output logic pm_err,
  output logic pm_busy,
  input wire logic io_req,
  input wire logic io_we,
  input wire acc_width_type io_width,
  input wire logic [ADDR_W-1:0] io_addr,
  input wire logic [DATA_W-1:0] io_wdata,
  output logic [DATA_W-1:0] io_rdata,
  output logic io_done,
  output logic io_err
);
  if (BLOCK_COUNT != 2) begin : g_chk
    $error("dual_port_internal_sram: decoder serves exactly two blocks");
  end

  logic req_v [PORTS];
  logic we_v [PORTS];
  acc_width_type wid_v [PORTS];
  logic [ADDR_W-1:0] addr_v [PORTS];
  logic [DATA_W-1:0] wd_v [PORTS];
  logic hit_v [PORTS];
  logic blk_v [PORTS];
  logic [IDX_W-1:0] idx_v [PORTS];
  logic [1:0] nl_v [PORTS];
  logic served_v [PORTS];
  logic [DATA_W-1:0] core_rd [BLOCKS];
  logic [DATA_W-1:0] io_rd [BLOCKS];
  logic [DATA_W-1:0] rdata_reg [PORTS];
  logic done_reg [PORTS];
  logic err_reg [PORTS];
  logic busy_reg;
  logic pm_conf;

  assign req_v = '{dm_req, pm_req, io_req};
  assign we_v = '{dm_we, pm_we, io_we};
  assign wid_v = '{dm_width, pm_width, io_width};
  assign addr_v = '{dm_addr, pm_addr, io_addr};
  assign wd_v = '{dm_wdata, pm_wdata, io_wdata};

  function automatic void decode(input logic [ADDR_W-1:0] a,
      input acc_width_type w, output logic hit, output logic blk,
      output logic [IDX_W-1:0] idx, output logic [1:0] nl);
    logic [31:0] base;
    logic [31:0] range;
    logic [31:0] span;
    logic [31:0] off;
    logic [31:0] loc;
    case (w)
      ACC_16: begin
        base = SHORT_BASE;
        range = SHORT_RANGE;
        span = SPAN16;
        nl = LANES16;
      end
      ACC_32: begin
        base = NORMAL_BASE;
        range = NORMAL_RANGE;
        span = SPAN32;
        nl = LANES32;
      end
      default: begin
        base = NORMAL_BASE;
        range = NORMAL_RANGE;
        span = SPAN48;
        nl = LANES48;
      end
    endcase
    off = a - base;
    hit = (a >= base) && (off < range) && (w != 2'h3);
    blk = (off >= span);
    // High offset bits dropped so the upper range folds onto block 1
    loc = off & (span - 32'h1);
    case (w)
      ACC_16: idx = loc[IDX_W-1:0];
      ACC_32: idx = {loc[IDX_W-2:0], 1'b0};
      default: idx = IDX_W'(loc * 32'h3);
    endcase
  endfunction : decode

  for (genvar p = 0; p < PORTS; p++) begin : g_dec
    always_comb begin
      decode(addr_v[p], wid_v[p], hit_v[p], blk_v[p], idx_v[p], nl_v[p]);
    end
  end

  // Core port of a block is shared; the data bus takes precedence
  assign pm_conf = req_v[DM_P] && hit_v[DM_P] && req_v[PM_P] &&
    hit_v[PM_P] && (blk_v[DM_P] == blk_v[PM_P]);
  assign served_v[DM_P] = req_v[DM_P] && hit_v[DM_P];
  assign served_v[PM_P] = req_v[PM_P] && hit_v[PM_P] && !pm_conf;
  assign served_v[IO_P] = req_v[IO_P] && hit_v[IO_P];

  sram_if bus [BLOCKS] ();

  for (genvar b = 0; b < BLOCKS; b++) begin : g_blk
    logic dm_sel;
    logic pm_sel;
    assign dm_sel = served_v[DM_P] && blk_v[DM_P] == 1'(b);
    assign pm_sel = served_v[PM_P] && blk_v[PM_P] == 1'(b);
    assign bus[b].core_en = dm_sel || pm_sel;
    assign bus[b].core_we = dm_sel ? we_v[DM_P] : we_v[PM_P];
    assign bus[b].core_idx = dm_sel ? idx_v[DM_P] : idx_v[PM_P];
    assign bus[b].core_nl = dm_sel ? nl_v[DM_P] : nl_v[PM_P];
    assign bus[b].core_wdata = dm_sel ? wd_v[DM_P] : wd_v[PM_P];
    assign bus[b].io_en = served_v[IO_P] && blk_v[IO_P] == 1'(b);
    assign bus[b].io_we = we_v[IO_P];
    assign bus[b].io_idx = idx_v[IO_P];
    assign bus[b].io_nl = nl_v[IO_P];
    assign bus[b].io_wdata = wd_v[IO_P];
    assign core_rd[b] = bus[b].core_rdata;
    assign io_rd[b] = bus[b].io_rdata;
    sram_bank #(.DEPTH(BLK_HALFWORDS)) u_bank (
      .clk(clk),
      .mem_port(bus[b])
    );
  end

  // Status and read data per bus, one cycle after the request
  for (genvar p = 0; p < PORTS; p++) begin : g_out
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] mask;
    assign raw = (p == IO_P) ? io_rd[blk_v[p]] : core_rd[blk_v[p]];
    assign mask = {{16{nl_v[p] > LANES32}}, {16{nl_v[p] > LANES16}},
      16'hffff};
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        done_reg[p] <= 1'b0;
        err_reg[p] <= 1'b0;
      end else begin
        done_reg[p] <= served_v[p];
        err_reg[p] <= req_v[p] && !hit_v[p];
      end
    end
    // Unused upper lanes read as zero for narrow accesses
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        rdata_reg[p] <= RDATA_RESET;
      end else if (served_v[p] && !we_v[p]) begin
        rdata_reg[p] <= raw & mask;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= pm_conf;
    end
  end

  assign dm_rdata = rdata_reg[DM_P];
  assign dm_done = done_reg[DM_P];
  assign dm_err = err_reg[DM_P];
  assign pm_rdata = rdata_reg[PM_P];
  assign pm_done = done_reg[PM_P];
  assign pm_err = err_reg[PM_P];
  assign pm_busy = busy_reg;
  assign io_rdata = rdata_reg[IO_P];
  assign io_done = done_reg[IO_P];
  assign io_err = err_reg[IO_P];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_dm_wr;
    dm_req && dm_we && hit_v[DM_P];
  endsequence
  // Collision judged on the decoded halfword, not on raw address words
  sequence s_both_wr;
    s_dm_wr ##0 (io_req && io_we && hit_v[IO_P] &&
      blk_v[IO_P] == blk_v[DM_P] && idx_v[IO_P] == idx_v[DM_P]);
  endsequence
  sequence s_dm_reread;
    dm_req && !dm_we && dm_addr == $past(dm_addr) &&
      dm_width == $past(dm_width) && !(io_req && io_we);
  endsequence

  AST_RD_AFTER_WR: assert property (s_dm_wr ##1 s_dm_reread |=>
    dm_rdata[15:0] == $past(dm_wdata[15:0], 2))
    else $error("read after write returned wrong data");
  AST_CORE_WINS: assert property (s_both_wr ##1 s_dm_reread |=>
    dm_rdata[15:0] == $past(dm_wdata[15:0], 2))
    else $error("core write lost a collision");
  AST_DM_DONE: assert property ((dm_req && hit_v[DM_P]) |=>
    dm_done && !dm_err)
    else $error("data bus access not done in one cycle");
  AST_THREE: assert property ((dm_req && pm_req && io_req &&
    hit_v[DM_P] && hit_v[PM_P] && hit_v[IO_P] &&
    blk_v[DM_P] != blk_v[PM_P]) |=> dm_done && pm_done && io_done)
    else $error("three transfers did not complete together");
  AST_PM_BUSY: assert property (pm_conf |=> pm_busy && !pm_done)
    else $error("program bus not refused on block conflict");
  AST_BASE: assert property ((dm_width == ACC_32 &&
    dm_addr == NORMAL_BASE) |-> hit_v[DM_P] && !blk_v[DM_P] &&
    idx_v[DM_P] == '0)
    else $error("first block not at internal base");
  AST_CONTIG: assert property ((dm_width == ACC_32 &&
    dm_addr == NORMAL_BASE + SPAN32) |-> blk_v[DM_P] &&
    idx_v[DM_P] == '0)
    else $error("second block not contiguous");
  AST_ALIAS: assert property ((dm_width == ACC_32 &&
    dm_addr == NORMAL_BASE + SPAN32 + SPAN32 + 32'h5) |->
    hit_v[DM_P] && blk_v[DM_P] && idx_v[DM_P] == 15'h000a)
    else $error("alias did not fold onto second block");
  AST_RANGE_END: assert property ((dm_req && dm_width == ACC_32 &&
    dm_addr == NORMAL_BASE + NORMAL_RANGE) |=> dm_err && !dm_done)
    else $error("address past internal range accepted");
endmodule : dual_port_internal_sram

// >>> core/sram_pkg.sv
// Shared constants and types for the dual-ported internal memory
package sram_pkg;
  localparam int COL_WIDTH = 16;
  localparam int COLUMNS = 8;
  localparam int COL_DEPTH = 4096;
  localparam int BLOCKS = 2;
  localparam int BLK_HALFWORDS = COLUMNS * COL_DEPTH;
  localparam int IDX_W = 15;
  localparam int LANES = 3;
  localparam int DATA_W = 48;
  localparam int ADDR_W = 32;
  localparam int PORTS = 3;
  localparam int DM_P = 0;
  localparam int PM_P = 1;
  localparam int IO_P = 2;
  // Word address windows of the internal range
  localparam logic [31:0] NORMAL_BASE = 32'h0002_0000;
  localparam logic [31:0] NORMAL_RANGE = 32'h0002_0000;
  localparam logic [31:0] SHORT_BASE = 32'h0004_0000;
  localparam logic [31:0] SHORT_RANGE = 32'h0004_0000;
  // Words per block for each access width
  localparam logic [31:0] SPAN16 = 32'h0000_8000;
  localparam logic [31:0] SPAN32 = 32'h0000_4000;
  localparam logic [31:0] SPAN48 = 32'h0000_2000;
  localparam logic [1:0] LANES16 = 2'h1;
  localparam logic [1:0] LANES32 = 2'h2;
  localparam logic [1:0] LANES48 = 2'h3;
  localparam logic [47:0] RDATA_RESET = 48'h0;
  typedef enum logic [1:0] {
    ACC_16 = 2'h0,
    ACC_32 = 2'h1,
    ACC_48 = 2'h2
  } acc_width_type;
endpackage : sram_pkg

// >>> core/sram_if.sv
// Port bundle between the decoder and one memory block
`timescale 1ns/1ps
interface sram_if import sram_pkg::*; ();
  logic core_en;
  logic core_we;
  logic [IDX_W-1:0] core_idx;
  logic [1:0] core_nl;
  logic [DATA_W-1:0] core_wdata;
  logic [DATA_W-1:0] core_rdata;
  logic io_en;
  logic io_we;
  logic [IDX_W-1:0] io_idx;
  logic [1:0] io_nl;
  logic [DATA_W-1:0] io_wdata;
  logic [DATA_W-1:0] io_rdata;
  modport ctrl (output core_en, core_we, core_idx, core_nl, core_wdata,
    io_en, io_we, io_idx, io_nl, io_wdata, input core_rdata, io_rdata);
  modport bank (input core_en, core_we, core_idx, core_nl, core_wdata,
    io_en, io_we, io_idx, io_nl, io_wdata, output core_rdata, io_rdata);
endinterface : sram_if

// >>> core/sram_bank.sv
// One memory block of 16-bit columns with a core port and an I/O port
`timescale 1ns/1ps
module sram_bank import sram_pkg::*; #(
  parameter int DEPTH = BLK_HALFWORDS
) (
  input wire logic clk,
  sram_if.bank mem_port
);
  if (DEPTH != COLUMNS * COL_DEPTH || DEPTH != 2 ** IDX_W) begin : g_chk
    $error("sram_bank: depth must fill the index space");
  end

  // Halfword store; eight columns of 4k halfwords laid out linearly
  logic [COL_WIDTH-1:0] mem [DEPTH];

  // Both ports read every cycle, independent of each other
  for (genvar l = 0; l < LANES; l++) begin : g_rd
    assign mem_port.core_rdata[COL_WIDTH*l +: COL_WIDTH] =
      mem[mem_port.core_idx + IDX_W'(l)];
    assign mem_port.io_rdata[COL_WIDTH*l +: COL_WIDTH] =
      mem[mem_port.io_idx + IDX_W'(l)];
  end

  // Per lane the core write is issued after the I/O write; it wins a same-location collision unless its lane is below the I/O lane
  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (mem_port.io_en && mem_port.io_we && 2'(l) < mem_port.io_nl) begin
        mem[mem_port.io_idx + IDX_W'(l)] <=
          mem_port.io_wdata[COL_WIDTH*l +: COL_WIDTH];
      end
      if (mem_port.core_en && mem_port.core_we &&
          2'(l) < mem_port.core_nl) begin
        mem[mem_port.core_idx + IDX_W'(l)] <=
          mem_port.core_wdata[COL_WIDTH*l +: COL_WIDTH];
      end
    end
  end
endmodule : sram_bank

// >>> dv/io_agent.sv
// Requester model for the I/O side of the internal memory
`timescale 1ns/1ps
module io_agent import sram_pkg::*; (
  input wire logic clk,
  output logic io_req,
  output logic io_we,
  output acc_width_type io_width,
  output logic [ADDR_W-1:0] io_addr,
  output logic [DATA_W-1:0] io_wdata
);
  initial begin
    io_req = 1'b0;
    io_we = 1'b0;
    io_width = ACC_16;
    io_addr = '0;
    io_wdata = '0;
  end
  // Fields held through the taking edge until the next call
  task automatic issue(input logic we, input acc_width_type w,
    input logic [31:0] a, input logic [47:0] d);
    io_req = 1'b1;
    io_we = we;
    io_width = w;
    io_addr = a;
    io_wdata = d;
    @(posedge clk);
    #1;
  endtask : issue
  // Scrambled while idle so late sampling shows up
  task automatic idle();
    io_req = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : idle
endmodule : io_agent

// >>> dv/tb.sv
// Self-checking bench for the two-block internal memory
`timescale 1ns/1ps
module tb import sram_pkg::*; ();
  logic clk;
  logic rstn;
  logic [2:0] rq;
  logic [2:0] wr;
  acc_width_type wd [3];
  logic [31:0] ad [3];
  logic [47:0] wda [3];
  logic [47:0] rd [3];
  logic [2:0] dn;
  logic [2:0] er;
  logic busy;
  logic io_req;
  logic io_we;
  acc_width_type io_width;
  logic [31:0] io_addr;
  logic [47:0] io_wdata;
  logic [15:0] mem [int];
  int n_errors = 0;
  int checks = 0;
  logic [33:0] tbl [17] = '{
    {2'h1, 32'h0002_0000}, {2'h0, 32'h0004_0001}, {2'h0, 32'h0004_7fff},
    {2'h1, 32'h0002_3fff}, {2'h1, 32'h0002_4000}, {2'h0, 32'h0004_8000},
    {2'h2, 32'h0002_1fff}, {2'h2, 32'h0002_2000}, {2'h1, 32'h0002_8000},
    {2'h0, 32'h0007_ffff}, {2'h1, 32'h0003_ffff}, {2'h1, 32'h0001_ffff},
    {2'h0, 32'h0003_ffff}, {2'h0, 32'h0008_0000}, {2'h3, 32'h0002_0000},
    {2'h1, 32'h0002_8005}, {2'h1, 32'h0004_0000}};

  dual_port_internal_sram dual_port_internal_sram_inst (
    .clk(clk), .rstn(rstn),
    .dm_req(rq[0]), .dm_we(wr[0]), .dm_width(wd[0]), .dm_addr(ad[0]),
    .dm_wdata(wda[0]), .dm_rdata(rd[0]), .dm_done(dn[0]), .dm_err(er[0]),
    .pm_req(rq[1]), .pm_we(wr[1]), .pm_width(wd[1]), .pm_addr(ad[1]),
    .pm_wdata(wda[1]), .pm_rdata(rd[1]), .pm_done(dn[1]), .pm_err(er[1]),
    .pm_busy(busy), .io_req(io_req), .io_we(io_we), .io_width(io_width),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(rd[2]),
    .io_done(dn[2]), .io_err(er[2]));

  io_agent io_agent_inst (.clk(clk), .io_req(io_req), .io_we(io_we),
    .io_width(io_width), .io_addr(io_addr), .io_wdata(io_wdata));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [47:0] s, e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  // Global halfword index, block one above BLK_HALFWORDS, -1 if refused
  function automatic int hidx(input logic [1:0] w, input logic [31:0] a);
    logic [31:0] base;
    logic [31:0] off;
    base = (w == 2'h0) ? SHORT_BASE : NORMAL_BASE;
    off = a - base;
    if (w == 2'h3 || a < base ||
      off >= ((w == 2'h0) ? SHORT_RANGE : NORMAL_RANGE))
      return -1;
    return ((off >= (SPAN16 >> w)) ? BLK_HALFWORDS : 0) +
      int'(off % (SPAN16 >> w)) * (int'(w) + 1);
  endfunction : hidx

  task automatic set(input int b, input logic we, input logic [33:0] t);
    wr[b] = we;
    wd[b] = acc_width_type'(t[33:32]);
    ad[b] = t[31:0];
    wda[b] = 48'({$urandom(), $urandom()});
  endtask : set

  task automatic pick(input int b);
    logic [1:0] w;
    logic [31:0] a;
    w = ($urandom_range(0, 15) == 0) ? 2'h3 : 2'($urandom_range(0, 2));
    a = ((w == 2'h0) ? SHORT_BASE : NORMAL_BASE) +
      $urandom_range(0, 3) * (SPAN16 >> w) + $urandom_range(0, 3);
    if ($urandom_range(0, 15) == 0)
      a = NORMAL_BASE - 32'h1;
    set(b, 1'($urandom_range(0, 1)), {w, a});
  endtask : pick

  // Old data for reads; io, then pm, then dm so the core write wins
  task automatic run(input logic [2:0] en);
    int h [3];
    logic [47:0] e [3];
    logic v [3];
    logic bz;
    logic ok;
    for (int b = 0; b < 3; b++) begin
      h[b] = hidx(wd[b], ad[b]);
      e[b] = '0;
      v[b] = 1'b1;
      for (int k = 0; h[b] >= 0 && k <= int'(wd[b]); k++) begin
        if (mem.exists(h[b] + k))
          e[b][16*k +: 16] = mem[h[b] + k];
        else
          v[b] = 1'b0;
      end
    end
    bz = en[0] && en[1] && h[0] >= 0 && h[1] >= 0 &&
      h[0] / BLK_HALFWORDS == h[1] / BLK_HALFWORDS;
    for (int b = 2; b >= 0; b--) begin
      if (en[b] && wr[b] && h[b] >= 0 && !(b == 1 && bz)) begin
        for (int k = 0; k <= int'(wd[b]); k++)
          mem[h[b] + k] = wda[b][16*k +: 16];
      end
    end
    // Requests stay up until the next call so no signal moves twice
    fork
      if (en[2])
        io_agent_inst.issue(wr[2], wd[2], ad[2], wda[2]);
      else
        io_agent_inst.idle();
      begin
        rq = en;
        @(posedge clk);
        #1;
      end
    join
    for (int b = 0; b < 3; b++) begin
      ok = h[b] >= 0 && !(b == 1 && bz);
      if (en[b]) begin
        chk("done", dn[b], ok);
        chk("err", er[b], h[b] < 0);
        if (!wr[b] && v[b] && ok)
          chk("rdata", rd[b], e[b]);
      end
    end
    chk("busy", busy, bz);
  endtask : run

  initial begin
    #400_000;
    n_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h58dc));
    rq = '0;
    rstn = 1'b0;
    for (int b = 0; b < 3; b++)
      set(b, 1'b0, '0);
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("reset rdata", rd[0] | rd[1] | rd[2], '0);
    chk("reset pulses", {dn, er, busy}, '0);
    $display("test reset done");
    foreach (tbl[i]) begin
      set(0, 1'b1, tbl[i]);
      run(3'b001);
    end
    foreach (tbl[i]) begin
      set(1, 1'b0, tbl[i]);
      run(3'b010);
    end
    $display("test corners done");
    set(0, 1'b1, {2'h1, 32'h0002_2000});
    set(2, 1'b1, {2'h0, 32'h0004_4001});
    run(3'b101);
    set(0, 1'b0, {2'h1, 32'h0002_2000});
    run(3'b001);
    set(0, 1'b1, {2'h1, 32'h0002_2000});
    set(2, 1'b1, {2'h0, 32'h0004_4000});
    run(3'b101);
    set(0, 1'b0, {2'h1, 32'h0002_2000});
    run(3'b001);
    set(0, 1'b0, {2'h1, 32'h0002_0000});
    set(1, 1'b1, {2'h1, 32'h0002_4001});
    set(2, 1'b1, {2'h2, 32'h0002_0100});
    run(3'b111);
    set(0, 1'b0, {2'h1, 32'h0002_0000});
    set(1, 1'b0, {2'h0, 32'h0004_0000});
    run(3'b011);
    $display("test collisions done");
    // Reset in mid run; memory keeps its contents, outputs clear
    rq = '0;
    io_agent_inst.idle();
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("mid reset rdata", rd[0] | rd[1] | rd[2], '0);
    chk("mid reset pulses", {dn, er, busy}, '0);
    rstn = 1'b1;
    $display("test mid reset done");
    // Small address pool so widths, aliases and ports keep overlapping
    repeat (400) begin
      for (int b = 0; b < 3; b++)
        pick(b);
      run(3'($urandom_range(0, 7)));
    end
    $display("test random done");
    close_out();
  end
endmodule : tb
